// ===== hdl/cbi_bus_cycle_engine.sv
// Bus cycle engine: machine cycle sequencer, pointers and AHB-Lite register slave
// Function
// - Sixteen-bit stack pointer, decremented on push, incremented on pop.
// - Sixteen-bit program counter, advanced on every opcode fetch but held on interrupt acknowledge.
// - Peripheral reset output stays high while the engine is in reset.
// - Space select high for I/O cycles, low for memory, floated when granted.
// - Refresh strobe low during third and fourth T-states of each opcode fetch.
// - Address strobe pulses in T1 of every cycle and T3 of opcode fetches.
// - Read data is captured at the trailing edge of the read strobe.
// - Write data stands on the shared lines while the write strobe is low.
// - Oscillator divided by two gives the square-wave system clock.
// - Interrupt sampled in last T-state; acknowledge low in T2 of next cycle.
// - Two status outputs encode halt, write, read or opcode fetch.
// - Shared lines carry low address or port address, then data.
// - Granted bus floats address, data and control, bus acknowledge held low.
// - Reset clears program counter, vector base and refresh counter.
// - Reset disables interrupts, sets control nibble to one, selects mode zero.
// - During reset lines float and all strobes stay inactive.
// - One system clock per T-state; opcode fetch lasts four T-states.
// - A single machine cycle may complete a whole instruction.
// - Hold request is granted only after the current cycle ends.
// - Every I/O cycle gets one self-generated wait state.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module cbi_bus_cycle_engine (
  input wire logic hclk, // Oscillator and bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word transfers only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire cbi_pkg::cbi_pins_in_t pins_i, // System bus inputs
  output cbi_pkg::cbi_pins_out_t pins_o // System bus outputs
);

  typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_TW, S_T3, S_T4, S_HOLD} cbi_state_t;

  cbi_state_t state_reg, ns;
  cbi_pkg::cbi_pins_out_t po_reg;
  cbi_pkg::cbi_cyc_t cmd_type_reg, cur_type_reg;
  logic rst_s1_reg, rst_s2_reg, run, ph_reg, t_en;
  logic wr_pend_reg, hready_reg, hresp_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg, rd_val;
  logic cmd_valid_reg, cmd_last_reg, cur_last_reg, cur_ack_reg;
  logic [7:0] cmd_data_reg, cur_data_reg, rdata_reg, vec_reg, ref_reg;
  logic [15:0] tgt_reg, pc_reg, sp_reg, cur_addr_reg, st_addr;
  logic irq_en_reg, irq_pend_reg, busy, start, cyc_end, cap;
  logic [1:0] irq_mode_reg;
  logic [3:0] irq_control_reg;
  logic opcode_fetch_cycle, is_four, is_io, is_rd, is_wr, is_halt;

  // ------------------------------------------------------------------
  // Reset and clock
  // ------------------------------------------------------------------

  // reset synchroniser
  // First stage is read only by the second, so release is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign run = rst_s2_reg;

  // divide by two
  // Runs from async release so the system clock toggles during sync reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
    end
  end

  // one T-state per system clock, stepped on its rising edge
  assign t_en = run & ~ph_reg;

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------

  // Zero-wait slave; read data is snapshotted in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= hsel & htrans[1] & hready & hwrite;
      wr_addr_reg <= haddr[7:0];
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        hrdata_reg <= rd_val;
      end else begin
        hrdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      cbi_pkg::CBI_OFF_CTRL: begin
        rd_val[cbi_pkg::CBI_CTRL_IEN] = irq_en_reg;
        rd_val[cbi_pkg::CBI_CTRL_MODE +: 2] = irq_mode_reg;
        rd_val[cbi_pkg::CBI_CTRL_MASK +: 4] = irq_control_reg;
      end
      cbi_pkg::CBI_OFF_CMD: begin
        rd_val[cbi_pkg::CBI_STS_BUSY] = busy;
        rd_val[cbi_pkg::CBI_STS_PEND] = irq_pend_reg;
        rd_val[cbi_pkg::CBI_STS_HOLD] = state_reg == S_HOLD;
        rd_val[cbi_pkg::CBI_CMD_DATA +: 8] = cmd_data_reg;
      end
      cbi_pkg::CBI_OFF_ADDR: rd_val[15:0] = tgt_reg;
      cbi_pkg::CBI_OFF_PC: rd_val[15:0] = pc_reg;
      cbi_pkg::CBI_OFF_SP: rd_val[15:0] = sp_reg;
      cbi_pkg::CBI_OFF_DATA: rd_val[7:0] = rdata_reg;
      cbi_pkg::CBI_OFF_VREF: begin
        rd_val[7:0] = vec_reg;
        rd_val[cbi_pkg::CBI_VREF_REF +: 8] = ref_reg;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Cycle decode
  // ------------------------------------------------------------------

  function automatic logic [1:0] stat_of(input cbi_pkg::cbi_cyc_t t, input logic a);
    logic [1:0] s;
    s = cbi_pkg::CBI_STAT_READ;
    if (a || t == cbi_pkg::CBI_CYC_FETCH) begin
      s = cbi_pkg::CBI_STAT_FETCH;
    end else if (t == cbi_pkg::CBI_CYC_HALT) begin
      s = cbi_pkg::CBI_STAT_HALT;
    end else if (t == cbi_pkg::CBI_CYC_MWR || t == cbi_pkg::CBI_CYC_IOWR ||
                 t == cbi_pkg::CBI_CYC_PUSH) begin
      s = cbi_pkg::CBI_STAT_WRITE;
    end
    return s;
  endfunction

  // Properties of the running cycle
  always_comb begin
    opcode_fetch_cycle = cur_ack_reg | (cur_type_reg == cbi_pkg::CBI_CYC_FETCH);
    is_halt = !cur_ack_reg && cur_type_reg == cbi_pkg::CBI_CYC_HALT;
    is_four = opcode_fetch_cycle | is_halt;
    is_io = !cur_ack_reg && (cur_type_reg == cbi_pkg::CBI_CYC_IORD ||
                             cur_type_reg == cbi_pkg::CBI_CYC_IOWR);
    is_rd = !cur_ack_reg && (cur_type_reg == cbi_pkg::CBI_CYC_MRD ||
                             cur_type_reg == cbi_pkg::CBI_CYC_IORD ||
                             cur_type_reg == cbi_pkg::CBI_CYC_POP);
    is_wr = !cur_ack_reg && (cur_type_reg == cbi_pkg::CBI_CYC_MWR ||
                             cur_type_reg == cbi_pkg::CBI_CYC_IOWR ||
                             cur_type_reg == cbi_pkg::CBI_CYC_PUSH);
  end

  // Address of the cycle about to start; I/O port repeats on both bytes
  always_comb begin
    case (cmd_type_reg)
      cbi_pkg::CBI_CYC_MRD, cbi_pkg::CBI_CYC_MWR: st_addr = tgt_reg;
      cbi_pkg::CBI_CYC_IORD, cbi_pkg::CBI_CYC_IOWR: st_addr = {tgt_reg[7:0], tgt_reg[7:0]};
      cbi_pkg::CBI_CYC_PUSH: st_addr = sp_reg - 16'h0001;
      cbi_pkg::CBI_CYC_POP: st_addr = sp_reg;
      default: st_addr = pc_reg;
    endcase
    if (irq_pend_reg) begin
      st_addr = pc_reg;
    end
  end

  // ------------------------------------------------------------------
  // Machine cycle sequencer
  // ------------------------------------------------------------------

  always_comb begin
    ns = state_reg;
    if (t_en) begin
      case (state_reg)
        S_IDLE: begin
          if (!pins_i.bus_hold_request_n) begin
            ns = S_HOLD;
          end else if (irq_pend_reg || cmd_valid_reg) begin
            ns = S_T1;
          end
        end
        S_T1: ns = S_T2;
        // I/O always passes through one wait state
        S_T2: begin
          if (is_halt) begin
            ns = S_T3;
          end else if (is_io || !pins_i.wait_n) begin
            ns = S_TW;
          end else begin
            ns = S_T3;
          end
        end
        S_TW: begin
          if (pins_i.wait_n) begin
            ns = S_T3;
          end
        end
        S_T3: ns = is_four ? S_T4 : S_IDLE;
        S_T4: ns = S_IDLE;
        S_HOLD: begin
          if (pins_i.bus_hold_request_n) begin
            ns = S_IDLE;
          end
        end
        default: ns = S_IDLE;
      endcase
    end
  end

  assign start = t_en && state_reg == S_IDLE && ns == S_T1;
  assign cyc_end = t_en && ns == S_IDLE && (state_reg == S_T3 || state_reg == S_T4);
  assign busy = cmd_valid_reg | (state_reg != S_IDLE && state_reg != S_HOLD);
  assign cap = t_en && ns != state_reg &&
               ((opcode_fetch_cycle && ns == S_T3) || (is_rd && ns == S_IDLE));

  // State and latched cycle; a pending interrupt preempts the queued command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      cur_type_reg <= cbi_pkg::CBI_CYC_FETCH;
      cur_last_reg <= 1'b0;
      cur_ack_reg <= 1'b0;
      cur_addr_reg <= 16'h0000;
      cur_data_reg <= 8'h00;
    end else begin
      state_reg <= ns;
      if (start) begin
        cur_type_reg <= cmd_type_reg;
        cur_last_reg <= cmd_last_reg & ~irq_pend_reg;
        cur_ack_reg <= irq_pend_reg;
        cur_addr_reg <= st_addr;
        cur_data_reg <= cmd_data_reg;
      end
    end
  end

  // Command queue of one; writes while busy are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_valid_reg <= 1'b0;
      cmd_type_reg <= cbi_pkg::CBI_CYC_FETCH;
      cmd_last_reg <= 1'b0;
      cmd_data_reg <= 8'h00;
    end else if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_CMD && !busy) begin
      cmd_valid_reg <= 1'b1;
      cmd_type_reg <= cbi_pkg::cbi_cyc_t'(hwdata[cbi_pkg::CBI_CMD_TYPE +: 3]);
      // last-cycle flag lets one cycle finish an instruction
      cmd_last_reg <= hwdata[cbi_pkg::CBI_CMD_LAST];
      cmd_data_reg <= hwdata[cbi_pkg::CBI_CMD_DATA +: 8];
    end else if (start && !irq_pend_reg) begin
      cmd_valid_reg <= 1'b0;
    end
  end

  // pointers, vector base and refresh counter cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_reg <= cbi_pkg::CBI_PC_RST;
      sp_reg <= cbi_pkg::CBI_SP_RST;
      vec_reg <= cbi_pkg::CBI_VEC_RST;
      ref_reg <= cbi_pkg::CBI_REF_RST;
      tgt_reg <= 16'h0000;
    end else begin
      if (start && !irq_pend_reg && cmd_type_reg == cbi_pkg::CBI_CYC_FETCH) begin
        pc_reg <= pc_reg + 16'h0001;
      end else if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_PC && !busy) begin
        pc_reg <= hwdata[15:0];
      end
      // pre-decrement on push, post-increment on pop
      if (start && !irq_pend_reg && cmd_type_reg == cbi_pkg::CBI_CYC_PUSH) begin
        sp_reg <= sp_reg - 16'h0001;
      end else if (start && !irq_pend_reg && cmd_type_reg == cbi_pkg::CBI_CYC_POP) begin
        sp_reg <= sp_reg + 16'h0001;
      end else if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_SP && !busy) begin
        sp_reg <= hwdata[15:0];
      end
      // Refresh counter steps after each opcode fetch
      if (cyc_end && opcode_fetch_cycle) begin
        ref_reg <= ref_reg + 8'h01;
      end else if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_VREF && !busy) begin
        vec_reg <= hwdata[7:0];
        ref_reg <= hwdata[cbi_pkg::CBI_VREF_REF +: 8];
      end
      if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_ADDR && !busy) begin
        tgt_reg <= hwdata[15:0];
      end
    end
  end

  // interrupts off, control nibble one, mode zero after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_reg <= 1'b0;
      irq_mode_reg <= cbi_pkg::CBI_MODE_RST;
      irq_control_reg <= cbi_pkg::CBI_MASK_RST;
    end else if (start && irq_pend_reg) begin
      irq_en_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == cbi_pkg::CBI_OFF_CTRL) begin
      irq_en_reg <= hwdata[cbi_pkg::CBI_CTRL_IEN];
      irq_mode_reg <= hwdata[cbi_pkg::CBI_CTRL_MODE +: 2];
      irq_control_reg <= hwdata[cbi_pkg::CBI_CTRL_MASK +: 4];
    end
  end

  // sample request in the final T-state of an instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_reg <= 1'b0;
    end else if (cyc_end && cur_last_reg && irq_en_reg && irq_control_reg[0] &&
                 pins_i.general_irq_request) begin
      irq_pend_reg <= 1'b1;
    end else if (start && irq_pend_reg) begin
      irq_pend_reg <= 1'b0;
    end
  end

  // capture on the edge that lifts the read or acknowledge strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 8'h00;
    end else if (cap) begin
      rdata_reg <= pins_i.ad_in;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------

  // lines float and strobes idle until the synchroniser releases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      po_reg <= cbi_pkg::CBI_PINS_RST;
    end else if (!run) begin
      // peripheral reset follows the engine's own reset
      po_reg <= cbi_pkg::CBI_PINS_RST;
      po_reg.sys_clk <= ~ph_reg;
    end else begin
      po_reg.sys_clk <= ~ph_reg;
      po_reg.reset_out <= 1'b0;
      // strobe is one oscillator period, falling mid T-state
      po_reg.ale <= 1'b0;
      if (t_en && ns != state_reg) begin
        case (ns)
          // address on the shared lines at the strobe's fall
          S_T1: begin
            po_reg.ale <= 1'b1;
            po_reg.addr_hi <= st_addr[15:8];
            po_reg.ad_out <= st_addr[7:0];
            po_reg.addr_hi_oe <= 1'b1;
            po_reg.ad_oe <= 1'b1;
            po_reg.ctrl_oe <= 1'b1;
            // space select from the cycle type
            po_reg.io_m <= !irq_pend_reg && (cmd_type_reg == cbi_pkg::CBI_CYC_IORD ||
                                             cmd_type_reg == cbi_pkg::CBI_CYC_IOWR);
            {po_reg.cycle_status_high, po_reg.cycle_status_low} <=
              stat_of(cmd_type_reg, irq_pend_reg);
          end
          // write data put on at the edge the strobe falls, kept to cycle end
          S_T2: begin
            po_reg.ad_out <= cur_data_reg;
            po_reg.ad_oe <= is_wr;
            po_reg.rd_n <= !(is_rd || (opcode_fetch_cycle && !cur_ack_reg));
            po_reg.wr_n <= !is_wr;
            po_reg.irq_acknowledge_n <= !cur_ack_reg;
          end
          // refresh address and strobe in T3 and T4 of fetches
          S_T3: begin
            if (opcode_fetch_cycle) begin
              po_reg.ale <= 1'b1;
              po_reg.addr_hi <= vec_reg;
              po_reg.ad_out <= ref_reg;
              po_reg.ad_oe <= 1'b1;
              po_reg.refresh_strobe_n <= 1'b0;
              po_reg.rd_n <= 1'b1;
              po_reg.irq_acknowledge_n <= 1'b1;
            end
          end
          S_IDLE: begin
            po_reg.rd_n <= 1'b1;
            po_reg.wr_n <= 1'b1;
            po_reg.refresh_strobe_n <= 1'b1;
            po_reg.irq_acknowledge_n <= 1'b1;
            po_reg.ad_oe <= 1'b0;
            if (state_reg == S_HOLD) begin
              po_reg.addr_hi_oe <= 1'b1;
              po_reg.ctrl_oe <= 1'b1;
              po_reg.bus_ack_n <= 1'b1;
            end
          end
          // release every bus line and acknowledge the grant
          S_HOLD: begin
            po_reg.addr_hi_oe <= 1'b0;
            po_reg.ad_oe <= 1'b0;
            po_reg.ctrl_oe <= 1'b0;
            po_reg.bus_ack_n <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end
  assign pins_o = po_reg;

endmodule

// ===== hdl/cbi_pkg.sv
// Package: register map, reset values, cycle codes and pin bundles of the bus cycle engine
package cbi_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets on the AHB-Lite slave
  // ------------------------------------------------------------------
  localparam logic [7:0] CBI_OFF_CTRL = 8'h00;
  localparam logic [7:0] CBI_OFF_CMD = 8'h04;
  localparam logic [7:0] CBI_OFF_ADDR = 8'h08;
  localparam logic [7:0] CBI_OFF_PC = 8'h0C;
  localparam logic [7:0] CBI_OFF_SP = 8'h10;
  localparam logic [7:0] CBI_OFF_DATA = 8'h14;
  localparam logic [7:0] CBI_OFF_VREF = 8'h18;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CBI_CTRL_IEN = 0;
  localparam int CBI_CTRL_MODE = 1;
  localparam int CBI_CTRL_MASK = 4;
  localparam int CBI_CMD_TYPE = 0;
  localparam int CBI_CMD_LAST = 3;
  localparam int CBI_CMD_DATA = 8;
  localparam int CBI_STS_BUSY = 0;
  localparam int CBI_STS_PEND = 1;
  localparam int CBI_STS_HOLD = 2;
  localparam int CBI_VREF_REF = 8;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] CBI_PC_RST = 16'h0000;
  localparam logic [15:0] CBI_SP_RST = 16'h0000;
  localparam logic [7:0] CBI_VEC_RST = 8'h00;
  localparam logic [7:0] CBI_REF_RST = 8'h00;
  localparam logic [3:0] CBI_MASK_RST = 4'h1;
  localparam logic [1:0] CBI_MODE_RST = 2'h0;

  // ------------------------------------------------------------------
  // Cycle status codes, high bit first
  // ------------------------------------------------------------------
  localparam logic [1:0] CBI_STAT_HALT = 2'h0;
  localparam logic [1:0] CBI_STAT_WRITE = 2'h1;
  localparam logic [1:0] CBI_STAT_READ = 2'h2;
  localparam logic [1:0] CBI_STAT_FETCH = 2'h3;

  // Machine cycle commands
  typedef enum logic [2:0] {
    CBI_CYC_FETCH = 3'h0,
    CBI_CYC_MRD = 3'h1,
    CBI_CYC_MWR = 3'h2,
    CBI_CYC_IORD = 3'h3,
    CBI_CYC_IOWR = 3'h4,
    CBI_CYC_PUSH = 3'h5,
    CBI_CYC_POP = 3'h6,
    CBI_CYC_HALT = 3'h7
  } cbi_cyc_t;

  // Pins coming in from the system bus
  typedef struct packed {
    logic [7:0] ad_in;
    logic wait_n;
    logic bus_hold_request_n;
    logic general_irq_request;
  } cbi_pins_in_t;

  // Pins going out to the system bus
  typedef struct packed {
    logic [7:0] addr_hi;
    logic addr_hi_oe;
    logic [7:0] ad_out;
    logic ad_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic io_m;
    logic ctrl_oe;
    logic refresh_strobe_n;
    logic irq_acknowledge_n;
    logic cycle_status_high;
    logic cycle_status_low;
    logic bus_ack_n;
    logic reset_out;
    logic sys_clk;
  } cbi_pins_out_t;

  localparam cbi_pins_out_t CBI_PINS_RST = '{
    addr_hi: 8'h00, addr_hi_oe: 1'b0, ad_out: 8'h00, ad_oe: 1'b0, ale: 1'b0,
    rd_n: 1'b1, wr_n: 1'b1, io_m: 1'b0, ctrl_oe: 1'b0, refresh_strobe_n: 1'b1,
    irq_acknowledge_n: 1'b1, cycle_status_high: 1'b0, cycle_status_low: 1'b0,
    bus_ack_n: 1'b1, reset_out: 1'b1, sys_clk: 1'b0};

endpackage

// ===== bench/cbi_bus_cycle_engine_asserts.sv
// Checker of the system bus pin timing of the bus cycle engine
`timescale 1ns/100ps
module cbi_pins_chk (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Reset, active low
  input wire cbi_pkg::cbi_pins_out_t pins_o // System bus outputs
);
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ale_pulse: assert property (pins_o.ale |=> !pins_o.ale)
    else $error("address strobe longer than one clock");
  a_reset_quiet: assert property (pins_o.reset_out |-> pins_o.rd_n && pins_o.wr_n
    && !pins_o.ad_oe && !pins_o.addr_hi_oe) else $error("bus active during reset");
  a_clk_half: assert property ($past(hresetn) |-> pins_o.sys_clk ^ $past(pins_o.sys_clk))
    else $error("system clock missed a toggle");
  a_hold_float: assert property (!pins_o.bus_ack_n |-> !pins_o.ad_oe
    && !pins_o.addr_hi_oe && !pins_o.ctrl_oe) else $error("bus driven while granted");
  a_wr_data: assert property (!pins_o.wr_n && $past(!pins_o.wr_n) |->
    pins_o.ad_oe && $stable(pins_o.ad_out)) else $error("write data moved");
  a_refresh_strobe_n_len: assert property ($fell(pins_o.refresh_strobe_n) |->
    !pins_o.refresh_strobe_n [*4] ##1 pins_o.refresh_strobe_n) else $error("refresh length");
  a_wr_status: assert property (!pins_o.wr_n |->
    {pins_o.cycle_status_high, pins_o.cycle_status_low} == cbi_pkg::CBI_STAT_WRITE)
    else $error("write without write status");
  a_ack_status: assert property (!pins_o.irq_acknowledge_n |-> pins_o.wr_n
    && pins_o.cycle_status_high && pins_o.cycle_status_low) else $error("stray acknowledge");
endmodule
bind cbi_bus_cycle_engine cbi_pins_chk cbi_pins_chk_inst (.hclk, .hresetn, .pins_o);

// ===== bench/cbi_bus_partner.sv
// Memory and peripheral model on the far side of the system bus
`timescale 1ns/100ps
module cbi_bus_partner (
  input wire logic hclk, // Bus clock
  input wire logic slow, // Ask for extra wait states
  input wire cbi_pkg::cbi_pins_out_t pins_o, // Engine pins
  output logic [7:0] ad_in, // Shared lines as the engine sees them
  output logic wait_n // Wait request, active low
);
  logic [7:0] mem [256];
  logic [7:0] lo_addr = 8'h00;
  logic [7:0] last = 8'h00;
  logic [2:0] wcnt = 3'h0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Latch low address while the strobe is high; store bytes while writing
  always @(posedge hclk) begin
    if (pins_o.ale) lo_addr <= pins_o.ad_out;
    if (!pins_o.wr_n && pins_o.ad_oe) mem[lo_addr] <= pins_o.ad_out;
    last <= ad_in;
    wcnt <= (pins_o.rd_n && pins_o.wr_n) ? 3'h0 : wcnt + 3'(wcnt != 3'h7);
  end
  // Slow mode holds the cycle for the first clocks of a strobe
  assign wait_n = !(slow && wcnt < 3'h3);
  // drive data only under read
  // Released lines show the inverse so a stale byte cannot pass
  assign ad_in = (!pins_o.rd_n && pins_o.ctrl_oe) ? mem[lo_addr] : ~last;
endmodule

// ===== bench/cbi_bus_cycle_engine_test.sv
// Self-checking testbench of the bus cycle engine
`timescale 1ns/100ps
module cbi_bus_cycle_engine_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hold_n, irq, slow, wait_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ad_in;
  logic [19:0] got;
  cbi_pkg::cbi_pins_in_t pins_i;
  cbi_pkg::cbi_pins_out_t pins_o;
  int num_errors = 0;
  int n_checks = 0;
  // Strobe seen, space, status, then read, write, refresh and acknowledge clocks per type
  logic [19:0] exp_tab [8] = '{20'hB_2040, 20'hA_4000, 20'h9_0400, 20'hE_6000,
    20'hD_0600, 20'h9_0400, 20'hA_4000, 20'h8_0000};
  assign hready = hreadyout;
  assign pins_i = {ad_in, wait_n, hold_n, irq};
  cbi_bus_cycle_engine cbi_bus_cycle_engine_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pins_i, .pins_o);
  cbi_bus_partner cbi_bus_partner_inst (.hclk, .slow, .pins_o, .ad_in, .wait_n);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string w);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, w, g, e);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
    ahb(1'b0, a, 32'h0);
    check(rd, e, w);
  endtask
  task automatic cmd(input logic [2:0] ty, input logic last);
    ahb(1'b1, cbi_pkg::CBI_OFF_ADDR, 32'h0000_3412);
    ahb(1'b1, cbi_pkg::CBI_OFF_CMD, {16'h0, 8'h5A, 4'h0, last, ty});
  endtask
  // Counts strobe clocks over a window long enough for any cycle
  task automatic watch();
    got = 20'h0;
    repeat (30) begin
      @(posedge hclk);
      if (pins_o.ale === 1'b1) got[19:16] = {1'b1, pins_o.io_m, pins_o.cycle_status_high,
        pins_o.cycle_status_low};
      got[15:12] = got[15:12] + {3'b0, ~pins_o.rd_n};
      got[11:8] = got[11:8] + {3'b0, ~pins_o.wr_n};
      got[7:4] = got[7:4] + {3'b0, ~pins_o.refresh_strobe_n};
      got[3:0] = got[3:0] + {3'b0, ~pins_o.irq_acknowledge_n};
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    repeat (4) @(posedge hclk);
    check(32'(pins_o.reset_out), 32'h0, "reset out released");
    check(32'({hresp, hreadyout}), 32'h1, "bus answer");
    rchk(cbi_pkg::CBI_OFF_PC, 32'h0, "pc at reset");
    rchk(cbi_pkg::CBI_OFF_VREF, 32'h0, "vector and refresh");
    rchk(cbi_pkg::CBI_OFF_CTRL, 32'h0000_0010, "irq control");
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_cycles();
    for (int i = 0; i < 8; i++) begin
      cmd(3'(i), 1'b0);
      watch();
      check(32'(got), 32'(exp_tab[i]), "cycle shape");
      if (i == 5) rchk(cbi_pkg::CBI_OFF_SP, 32'h0000_FFFF, "sp pushed");
    end
    rchk(cbi_pkg::CBI_OFF_PC, 32'h1, "pc advanced");
    rchk(cbi_pkg::CBI_OFF_SP, 32'h0, "sp popped");
    rchk(cbi_pkg::CBI_OFF_VREF, 32'h0000_0100, "refresh count");
    cmd(3'h0, 1'b0);
    watch();
    slow <= 1'b1;
    cmd(3'h1, 1'b0);
    watch();
    slow <= 1'b0;
    check(32'(got[15:12] > 4'h4), 32'h1, "wait stretches read");
    rchk(cbi_pkg::CBI_OFF_DATA, 32'h5A, "read back");
    $display("test cycles done");
  endtask
  task automatic t_hold();
    int n = 0;
    int r = 1;
    cmd(3'h1, 1'b0);
    while (pins_o.rd_n !== 1'b0 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 20) begin num_errors++; finish_test(); end
    hold_n <= 1'b0;
    for (n = 0; pins_o.bus_ack_n !== 1'b0 && n < 20; n++) begin
      @(posedge hclk);
      r += int'(pins_o.rd_n === 1'b0);
    end
    if (n >= 20) begin num_errors++; finish_test(); end
    check(32'(r), 32'h4, "cycle finished before grant");
    cmd(3'h0, 1'b0);
    watch();
    check(32'(got[19:12]), 32'h0, "no cycle while granted");
    rchk(cbi_pkg::CBI_OFF_CMD, 32'h0000_5A05, "granted status");
    hold_n <= 1'b1;
    watch();
    check(32'({pins_o.bus_ack_n, got[19:16]}), 32'h1B, "fetch after release");
    $display("test hold done");
  endtask
  task automatic t_irq();
    ahb(1'b1, cbi_pkg::CBI_OFF_CTRL, 32'h0000_0011);
    irq <= 1'b1;
    cmd(3'h2, 1'b0);
    watch();
    check(32'(got[3:0]), 32'h0, "no ack mid instruction");
    cmd(3'h2, 1'b1);
    watch();
    irq <= 1'b0;
    check(32'(got[3:0]), 32'h2, "ack in T2");
    rchk(cbi_pkg::CBI_OFF_CTRL, 32'h0000_0010, "ack disables irq");
    $display("test irq done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hold_n = 1'b1;
    irq = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge hclk);
    check(32'(pins_o.reset_out), 32'h1, "reset out");
    check(32'({pins_o.ad_oe, pins_o.addr_hi_oe}), 32'h0, "float in reset");
    hresetn <= 1'b1;
    t_regs();
    t_cycles();
    t_hold();
    t_irq();
    finish_test();
  end
endmodule
